/* verilog/csd_pkg.sv */
// Package: register numbers, field positions and reset values of the bank
package csd_pkg;
   localparam logic [7:0] REG_SECURITY = 8'h05;
   localparam logic [7:0] REG_OSC_CTRL = 8'h06;
   localparam logic [7:0] REG_OSC_CORE_CELL = 8'h07;
   localparam logic [7:0] REG_OSC_CORE_WIRE = 8'h08;
   localparam logic [7:0] REG_OSC_PERIPH_CELL = 8'h09;
   localparam logic [7:0] REG_OSC_PERIPH_WIRE = 8'h0A;
   localparam logic [7:0] REG_RAM_SIZE = 8'h0C;
   localparam logic [7:0] REG_DBG_STATUS = 8'h10;
   localparam logic [7:0] REG_DBG_PC = 8'h11;
   localparam logic [7:0] REG_DBG_SP = 8'h12;
   localparam logic [7:0] REG_DBG_THREAD_SEL = 8'h13;
   localparam logic [7:0] REG_DBG_REG_SEL = 8'h14;
   localparam logic [7:0] REG_DBG_CAUSE = 8'h15;
   // Security word fields
   localparam int SEC_WRITE_LOCK = 31;
   localparam int SEC_NO_GLOBAL_DEBUG = 14;
   localparam int SEC_LOCK_ALL = 12;
   localparam int SEC_LOCK_LO = 8;
   localparam int SEC_REDUNDANCY = 7;
   localparam int SEC_OTP_BOOT = 5;
   localparam int SEC_NO_SCAN_CFG = 4;
   localparam int SEC_NO_SCAN_DEBUG = 0;
   localparam logic [31:0] SEC_WRITE_MASK = 32'h80005FB1;
   // Oscillator control fields
   localparam int OSC_CORE_EN = 1;
   localparam int OSC_PERIPH_EN = 0;
   localparam logic [1:0] OSC_CTRL_RESET = 2'h0;
   // Saved status word writable bits (10:9, 7:6, 4:0)
   localparam logic [10:0] STATUS_WRITE_MASK = 11'h6DF;
   localparam logic [7:0] THREAD_SEL_RESET = 8'h00;
   localparam logic [4:0] REG_SEL_RESET = 5'h00;
   // Debug cause encodings
   localparam logic [2:0] CAUSE_NONE = 3'h0;
   localparam logic [2:0] CAUSE_HOST = 3'h1;
   localparam logic [2:0] CAUSE_DEBUG_CALL_INSTRUCTION = 3'h2;
   localparam logic [2:0] CAUSE_IBREAK = 3'h3;
   localparam logic [2:0] CAUSE_DWATCH = 3'h4;
   localparam logic [2:0] CAUSE_RWATCH = 3'h5;
   localparam int CAUSE_UNIT_LO = 16;
   localparam int CAUSE_THREAD_LO = 8;
endpackage

/* verilog/csd_regs.sv */
// Processor status register bank: security, ring oscillators, debug capture
`timescale 1ns/1ps
// What this block does
// RULE_01: Security register loaded from OTP word
// RULE_02: Bit 31 set blocks further writes
// RULE_03: Bit 14 blocks global debug access
// RULE_04: Bit 0 denies scan debug TAP
// RULE_05: Bit 12, 11:8 lock OTP; 7 redundancy
// RULE_06: Bit 5 forces boot from OTP
// RULE_07: Bit 4 blocks scan PLL/boot access
// RULE_08: Four ring oscillators, each clocks counter
// RULE_09: Control bits start/stop core, peripheral oscillators
// RULE_10: Software reads counters after ten stopped cycles
// RULE_11: Four 16-bit counter registers in order
// RULE_12: Counters keep value through system reset
// RULE_13: Oscillators asynchronous, usable for random bits
// RULE_14: Read-only RAM size word, bits 31:2
// RULE_15: Debug entry captures saved status word
// RULE_16: Status bit 7 fast, bit 6 paused
// RULE_17: Status bits 4..0 kernel, handler, enables
// RULE_18: Debug entry captures saved PC and SP
// RULE_19: Thread select 7:0, register select 4:0
// RULE_20: Cause field 2:0 encodes entry reason
// RULE_21: Bits 17:16 lowest firing unit number
// RULE_22: Bits 15:8 thread number, host zero
// RULE_23: Registers reached by number via read/write
// RULE_24: Debug fields writable only in debug mode
module csd_regs
   import csd_pkg::*;
#(
   parameter int RAM_BYTES = 32'h00080000,
   parameter int OSC_WIDTH = 16
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // Status register access from the core
   input wire logic PS_WRITE,
   input wire logic PS_READ,
   input wire logic [7:0] PS_NUM,
   input wire logic [31:0] PS_WDATA,
   output logic [31:0] PS_RDATA,
   output logic PS_RVALID,
   // OTP security word load
   input wire logic OTP_LOAD,
   input wire logic [31:0] OTP_WORD,
   // Ring oscillator inputs, free running
   input wire logic [3:0] RING_OSC,
   // Debug entry capture
   input wire logic DEBUG_MODE,
   input wire logic DEBUG_ENTER,
   input wire logic [2:0] DEBUG_CAUSE,
   input wire logic [3:0] DEBUG_UNIT_HITS,
   input wire logic [7:0] DEBUG_THREAD,
   input wire logic [10:0] THREAD_STATUS,
   input wire logic [31:0] THREAD_PC,
   input wire logic [31:0] THREAD_SP,
   // Security controls
   output logic NO_GLOBAL_DEBUG,
   output logic NO_SCAN_DEBUG,
   output logic NO_SCAN_CONFIG,
   output logic OTP_LOCK_ALL,
   output logic [3:0] OTP_SECTOR_LOCK,
   output logic OTP_REDUNDANCY,
   output logic BOOT_FROM_OTP,
   // Debug operands
   output logic [7:0] FETCH_THREAD,
   output logic [4:0] FETCH_REG,
   // Oscillator enables
   output logic CORE_OSC_EN,
   output logic PERIPH_OSC_EN
);
   logic [31:0] security;
   logic [1:0] osc_ctrl;
   logic [10:0] saved_status_word;
   logic [31:0] saved_program_counter;
   logic [31:0] saved_stack_pointer;
   logic [7:0] thread_sel;
   logic [4:0] reg_sel;
   logic [2:0] cause;
   logic [1:0] cause_unit;
   logic [7:0] cause_thread;
   logic [OSC_WIDTH-1:0] osc_sync2 [4];
   logic [1:0] next_unit;
   logic [31:0] next_rdata;
   logic dbg_wr;
   logic [1:0] osc_run_ctl;
   logic wr_security;
   logic wr_osc_ctrl;
   logic wr_status;
   logic wr_pc;
   logic wr_sp;
   logic wr_thread_sel;
   logic wr_reg_sel;
   logic wr_cause;

   assign dbg_wr = PS_WRITE && DEBUG_MODE; // RULE_24
   assign osc_run_ctl = osc_ctrl;

   // Write strobes per register; debug registers need debug mode
   assign wr_security = PS_WRITE && PS_NUM == REG_SECURITY;
   assign wr_osc_ctrl = PS_WRITE && PS_NUM == REG_OSC_CTRL;
   assign wr_status = dbg_wr && PS_NUM == REG_DBG_STATUS; // RULE_24
   assign wr_pc = dbg_wr && PS_NUM == REG_DBG_PC; // RULE_24
   assign wr_sp = dbg_wr && PS_NUM == REG_DBG_SP; // RULE_24
   assign wr_thread_sel = dbg_wr && PS_NUM == REG_DBG_THREAD_SEL; // RULE_24
   assign wr_reg_sel = dbg_wr && PS_NUM == REG_DBG_REG_SEL; // RULE_24
   assign wr_cause = dbg_wr && PS_NUM == REG_DBG_CAUSE; // RULE_24

   // Security word; software writes stop once the lock bit is set
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         security <= 32'h00000000;
      end else if (OTP_LOAD) begin
         security <= OTP_WORD & SEC_WRITE_MASK; // RULE_01
      end else if (wr_security && !security[SEC_WRITE_LOCK]) begin // RULE_02
         security <= PS_WDATA & SEC_WRITE_MASK;
      end
   end

   // Debug and scan access blocks
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         NO_GLOBAL_DEBUG <= 1'b0;
         NO_SCAN_DEBUG <= 1'b0;
         NO_SCAN_CONFIG <= 1'b0;
      end else begin
         NO_GLOBAL_DEBUG <= security[SEC_NO_GLOBAL_DEBUG]; // RULE_03
         NO_SCAN_DEBUG <= security[SEC_NO_SCAN_DEBUG]; // RULE_04
         NO_SCAN_CONFIG <= security[SEC_NO_SCAN_CFG]; // RULE_07
      end
   end

   // OTP sector locks and redundancy
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         OTP_LOCK_ALL <= 1'b0;
         OTP_SECTOR_LOCK <= 4'h0;
         OTP_REDUNDANCY <= 1'b0;
      end else begin
         OTP_LOCK_ALL <= security[SEC_LOCK_ALL]; // RULE_05
         OTP_SECTOR_LOCK <= security[SEC_LOCK_LO +: 4]; // RULE_05
         OTP_REDUNDANCY <= security[SEC_REDUNDANCY]; // RULE_05
      end
   end

   // Boot source override
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         BOOT_FROM_OTP <= 1'b0;
      end else begin
         BOOT_FROM_OTP <= security[SEC_OTP_BOOT]; // RULE_06
      end
   end

   // Oscillator start/stop control
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         osc_ctrl <= OSC_CTRL_RESET; // RULE_09
      end else if (wr_osc_ctrl) begin
         osc_ctrl <= PS_WDATA[1:0];
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         CORE_OSC_EN <= 1'b0;
         PERIPH_OSC_EN <= 1'b0;
      end else begin
         CORE_OSC_EN <= osc_ctrl[OSC_CORE_EN]; // RULE_09
         PERIPH_OSC_EN <= osc_ctrl[OSC_PERIPH_EN]; // RULE_09
      end
   end

   // Each ring oscillator clocks its own counter; no reset so the
   // count survives a system reset, it starts from zero at power-up.
   // Index 0,1 core; 2,3 peripheral. The count crosses into the core
   // domain as gray code, so a sample taken while running is never torn.
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_osc
         logic run_sync1;
         logic run_sync2;
         logic [OSC_WIDTH-1:0] count = '0;
         logic [OSC_WIDTH-1:0] gray = '0;
         logic [OSC_WIDTH-1:0] next_count;
         logic [OSC_WIDTH-1:0] gray_sync1;
         logic [OSC_WIDTH-1:0] gray_sync2;
         logic [OSC_WIDTH-1:0] next_bin;
         assign next_count = count + 1'b1;
         always_ff @(posedge RING_OSC[g]) begin // RULE_08 RULE_13
            run_sync1 <= osc_run_ctl[g < 2 ? 1 : 0];
            run_sync2 <= run_sync1;
         end
         always_ff @(posedge RING_OSC[g]) begin // RULE_12
            if (run_sync2) begin
               count <= next_count;
               gray <= next_count ^ (next_count >> 1);
            end
         end
         // Sampled into the core domain; exact once stopped
         always_ff @(posedge REF_CLK) begin // RULE_10
            gray_sync1 <= gray;
            gray_sync2 <= gray_sync1;
         end
         always_comb begin
            next_bin = '0;
            for (int b = 0; b < OSC_WIDTH; b++) begin
               next_bin[b] = ^(gray_sync2 >> b);
            end
         end
         always_ff @(posedge REF_CLK) begin // RULE_11
            osc_sync2[g] <= next_bin;
         end
      end
   endgenerate

   // Lowest numbered unit wins when several hit together
   always_comb begin
      next_unit = 2'h0;
      if (DEBUG_UNIT_HITS[0]) begin
         next_unit = 2'h0;
      end else if (DEBUG_UNIT_HITS[1]) begin
         next_unit = 2'h1;
      end else if (DEBUG_UNIT_HITS[2]) begin
         next_unit = 2'h2;
      end else if (DEBUG_UNIT_HITS[3]) begin
         next_unit = 2'h3;
      end
   end

   // Saved status word; bits 8 and 5 keep their captured values
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         saved_status_word <= 11'h000;
      end else if (DEBUG_ENTER) begin
         saved_status_word <= THREAD_STATUS; // RULE_15 RULE_16 RULE_17
      end else if (wr_status) begin // RULE_24
         saved_status_word <= (PS_WDATA[10:0] & STATUS_WRITE_MASK) |
            (saved_status_word & ~STATUS_WRITE_MASK);
      end
   end

   // Saved program counter
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         saved_program_counter <= 32'h00000000;
      end else if (DEBUG_ENTER) begin
         saved_program_counter <= THREAD_PC; // RULE_18
      end else if (wr_pc) begin // RULE_24
         saved_program_counter <= PS_WDATA;
      end
   end

   // Saved stack pointer
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         saved_stack_pointer <= 32'h00000000;
      end else if (DEBUG_ENTER) begin
         saved_stack_pointer <= THREAD_SP; // RULE_18
      end else if (wr_sp) begin // RULE_24
         saved_stack_pointer <= PS_WDATA;
      end
   end

   // Debug cause code; entry wins over a same-cycle write
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         cause <= CAUSE_NONE; // RULE_20
      end else if (DEBUG_ENTER) begin
         cause <= DEBUG_CAUSE; // RULE_20
      end else if (wr_cause) begin // RULE_24
         cause <= PS_WDATA[2:0];
      end
   end

   // Firing unit number; zero for host requests and debug calls
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         cause_unit <= 2'h0;
      end else if (DEBUG_ENTER) begin
         if (DEBUG_CAUSE == CAUSE_HOST || DEBUG_CAUSE == CAUSE_DEBUG_CALL_INSTRUCTION) begin
            cause_unit <= 2'h0; // RULE_21
         end else begin
            cause_unit <= next_unit; // RULE_21
         end
      end else if (wr_cause) begin // RULE_24
         cause_unit <= PS_WDATA[CAUSE_UNIT_LO +: 2];
      end
   end

   // Raising thread; zero for host requests
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         cause_thread <= 8'h00;
      end else if (DEBUG_ENTER) begin
         if (DEBUG_CAUSE == CAUSE_HOST) begin
            cause_thread <= 8'h00; // RULE_22
         end else begin
            cause_thread <= DEBUG_THREAD; // RULE_22
         end
      end else if (wr_cause) begin // RULE_24
         cause_thread <= PS_WDATA[CAUSE_THREAD_LO +: 8];
      end
   end

   // Debug fetch operands
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         thread_sel <= THREAD_SEL_RESET;
      end else if (wr_thread_sel) begin
         thread_sel <= PS_WDATA[7:0]; // RULE_19
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         reg_sel <= REG_SEL_RESET;
      end else if (wr_reg_sel) begin
         reg_sel <= PS_WDATA[4:0]; // RULE_19
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         FETCH_THREAD <= THREAD_SEL_RESET;
         FETCH_REG <= REG_SEL_RESET;
      end else begin
         FETCH_THREAD <= thread_sel;
         FETCH_REG <= reg_sel;
      end
   end

   // Read decode by register number
   always_comb begin
      next_rdata = 32'h00000000;
      case (PS_NUM) // RULE_23
         REG_SECURITY: next_rdata = security;
         REG_OSC_CTRL: next_rdata = {30'h0, osc_ctrl};
         REG_OSC_CORE_CELL: next_rdata = 32'(osc_sync2[0]); // RULE_11
         REG_OSC_CORE_WIRE: next_rdata = 32'(osc_sync2[1]);
         REG_OSC_PERIPH_CELL: next_rdata = 32'(osc_sync2[2]);
         REG_OSC_PERIPH_WIRE: next_rdata = 32'(osc_sync2[3]);
         REG_RAM_SIZE: next_rdata = {RAM_BYTES[31:2], 2'h0}; // RULE_14
         REG_DBG_STATUS: next_rdata = {21'h0, saved_status_word};
         REG_DBG_PC: next_rdata = saved_program_counter;
         REG_DBG_SP: next_rdata = saved_stack_pointer;
         REG_DBG_THREAD_SEL: next_rdata = {24'h0, thread_sel};
         REG_DBG_REG_SEL: next_rdata = {27'h0, reg_sel};
         REG_DBG_CAUSE: next_rdata = {14'h0, cause_unit, cause_thread,
                                      5'h0, cause};
         default: next_rdata = 32'h00000000;
      endcase
   end

   // Read answer one cycle after the request
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         PS_RVALID <= 1'b0;
      end else begin
         PS_RVALID <= PS_READ;
      end
   end

   // Read data holds until the next read
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         PS_RDATA <= 32'h00000000;
      end else if (PS_READ) begin
         PS_RDATA <= next_rdata;
      end
   end
endmodule

/* testbench/csd_regs_properties.sv */
// Port checks for the status register bank
`timescale 1ns/1ps
module csd_regs_properties
   import csd_pkg::*;
#(
   parameter int RAM_BYTES = 32'h00080000
) (
   // Clock, reset and access
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic PS_WRITE,
   input wire logic PS_READ,
   input wire logic [7:0] PS_NUM,
   input wire logic [31:0] PS_WDATA,
   input wire logic [31:0] PS_RDATA,
   input wire logic PS_RVALID,
   // Loads and controls
   input wire logic OTP_LOAD,
   input wire logic [31:0] OTP_WORD,
   input wire logic DEBUG_MODE,
   input wire logic NO_GLOBAL_DEBUG,
   input wire logic NO_SCAN_DEBUG,
   input wire logic BOOT_FROM_OTP,
   input wire logic [7:0] FETCH_THREAD,
   input wire logic [4:0] FETCH_REG,
   input wire logic CORE_OSC_EN
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   logic [31:0] w1;
   logic [31:0] w2;
   always_ff @(posedge REF_CLK) begin
      w1 <= OTP_WORD;
      w2 <= w1;
   end
   a_read_answer: assert property (
      PS_READ |=> PS_RVALID) else $error("read not answered");
   a_no_stray_valid: assert property (
      !PS_READ |=> !PS_RVALID) else $error("valid without read");
   a_reset_clears: assert property (disable iff (1'b0)
      RST [*3] |=> !CORE_OSC_EN && FETCH_THREAD == 8'h00)
      else $error("outputs not cleared by reset");
   a_otp_copy: assert property (
      OTP_LOAD ##1 !(PS_WRITE || OTP_LOAD) |-> ##1
      {NO_GLOBAL_DEBUG, NO_SCAN_DEBUG, BOOT_FROM_OTP} == {w2[14], w2[0], w2[5]})
      else $error("security outputs differ from loaded word");
   a_osc_enable: assert property (
      PS_WRITE && PS_NUM == REG_OSC_CTRL |-> ##2
      CORE_OSC_EN == $past(PS_WDATA[1], 2)) else $error("core enable wrong");
   a_thread_sel: assert property (
      PS_WRITE && DEBUG_MODE && PS_NUM == REG_DBG_THREAD_SEL |-> ##2
      FETCH_THREAD == $past(PS_WDATA[7:0], 2)) else $error("thread sel wrong");
   a_reg_gated: assert property (
      PS_WRITE && !DEBUG_MODE && PS_NUM == REG_DBG_REG_SEL |-> ##2
      $stable(FETCH_REG)) else $error("register sel written outside debug");
   a_ram_size: assert property (
      PS_READ && PS_NUM == REG_RAM_SIZE |=> PS_RDATA == RAM_BYTES)
      else $error("ram size wrong");
endmodule

/* testbench/csd_core_model.sv */
// Core side model: issues status register reads and writes
`timescale 1ns/1ps
module csd_core_model (
   // Clock
   input wire logic clk,
   // Access requests
   output logic ps_write,
   output logic ps_read,
   output logic [7:0] ps_num,
   output logic [31:0] ps_wdata,
   // Read answer
   input wire logic [31:0] ps_rdata,
   input wire logic ps_rvalid
);
   initial {ps_write, ps_read, ps_num, ps_wdata} = '0;
   task automatic wr(input logic [7:0] n, input logic [31:0] d);
      @(posedge clk);
      ps_write <= 1'b1;
      ps_num <= n;
      ps_wdata <= d;
      @(posedge clk);
      ps_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] n, output logic [31:0] d);
      @(posedge clk);
      ps_read <= 1'b1;
      ps_num <= n;
      @(posedge clk);
      ps_read <= 1'b0;
      d = 'x;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         if (ps_rvalid === 1'b1) begin
            d = ps_rdata;
            break;
         end
      end
   endtask
endmodule

/* testbench/csd_regs_tb_top.sv */
// Self-checking bench for the status register bank
`timescale 1ns/1ps
module csd_regs_tb_top
   import csd_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, ld = 1'b0, dm = 1'b0, de = 1'b0;
   logic [3:0] rosc = 4'h0, hits = 4'h0;
   logic [2:0] cause = 3'h0;
   logic [7:0] thr = 8'h00, psn, ft;
   logic [10:0] st = 11'h000;
   logic [31:0] ow = 32'h0, pv = 32'h0, r, wd, rdat;
   logic [31:0] cnt [4];
   logic psw, psr, rv, ce, pe;
   logic [4:0] fr;
   logic [9:0] sec;
   int num_errors = 0, n_compared = 0, cycles = 0;
   always #25 clk = ~clk;
   always #7 rosc[0] = ~rosc[0];
   always #9 rosc[1] = ~rosc[1];
   always #11 rosc[2] = ~rosc[2];
   always #13 rosc[3] = ~rosc[3];
   csd_core_model core (.clk(clk), .ps_write(psw), .ps_read(psr),
      .ps_num(psn), .ps_wdata(wd), .ps_rdata(rdat), .ps_rvalid(rv));
   csd_regs #(.RAM_BYTES(32'h00080000), .OSC_WIDTH(16)) uut (
      .REF_CLK(clk), .RST(rst), .PS_WRITE(psw), .PS_READ(psr),
      .PS_NUM(psn), .PS_WDATA(wd), .PS_RDATA(rdat), .PS_RVALID(rv),
      .OTP_LOAD(ld), .OTP_WORD(ow), .RING_OSC(rosc), .DEBUG_MODE(dm),
      .DEBUG_ENTER(de), .DEBUG_CAUSE(cause), .DEBUG_UNIT_HITS(hits),
      .DEBUG_THREAD(thr), .THREAD_STATUS(st), .THREAD_PC(pv),
      .THREAD_SP(~pv), .NO_GLOBAL_DEBUG(sec[9]), .NO_SCAN_DEBUG(sec[8]),
      .NO_SCAN_CONFIG(sec[7]), .OTP_LOCK_ALL(sec[6]),
      .OTP_SECTOR_LOCK(sec[5:2]), .OTP_REDUNDANCY(sec[1]),
      .BOOT_FROM_OTP(sec[0]), .FETCH_THREAD(ft), .FETCH_REG(fr),
      .CORE_OSC_EN(ce), .PERIPH_OSC_EN(pe));
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rchk(input logic [7:0] n, input logic [31:0] e);
      core.rd(n, r);
      chk($sformatf("reg %h", n), e, r);
   endtask
   task automatic load(input logic [31:0] w);
      @(posedge clk);
      ld <= 1'b1;
      ow <= w;
      @(posedge clk);
      ld <= 1'b0;
   endtask
   task automatic wrap_up;
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         wrap_up();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rchk(REG_OSC_CTRL, 32'h0);
      rchk(REG_DBG_CAUSE, 32'h0);
      rchk(REG_RAM_SIZE, 32'h00080000);
      rchk(8'h0B, 32'h0);
      load(32'h00004011);
      core.wr(REG_SECURITY, 32'h000000A0);
      rchk(REG_SECURITY, 32'h000000A0);
      chk("security outputs", 32'h3, {22'h0, sec});
      load(32'hFFFFFFFF);
      rchk(REG_SECURITY, 32'h80005FB1);
      core.wr(REG_SECURITY, 32'h0);
      rchk(REG_SECURITY, 32'h80005FB1);
      chk("security outputs", 32'h3FF, {22'h0, sec});
      core.wr(REG_OSC_CTRL, 32'h3);
      repeat (2) @(posedge clk);
      chk("osc enables", 32'h3, {30'h0, ce, pe});
      repeat (100) @(posedge clk);
      core.wr(REG_OSC_CTRL, 32'h0);
      repeat (12) @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         core.rd(REG_OSC_CORE_CELL + 8'(i), cnt[i]);
         chk("osc count", 32'h1, {31'h0, cnt[i][15:0] != 16'h0});
         chk("osc upper", 32'h0, {cnt[i][31:16], 16'h0});
      end
      @(posedge clk) rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++) rchk(REG_OSC_CORE_CELL + 8'(i), cnt[i]);
      dm <= 1'b1;
      for (int c = 1; c <= 5; c++) begin
         @(posedge clk);
         de <= 1'b1;
         cause <= 3'(c);
         hits <= 4'b0110;
         thr <= 8'h2A;
         st <= 11'h2D5 ^ 11'(c);
         pv <= 32'h00400000 + 32'(c);
         @(posedge clk);
         de <= 1'b0;
         rchk(REG_DBG_CAUSE, {14'h0, (c > 2) ? 2'h1 : 2'h0,
            (c == 1) ? 8'h00 : 8'h2A, 5'h0, 3'(c)});
         rchk(REG_DBG_STATUS, {21'h0, 11'h2D5 ^ 11'(c)});
         rchk(REG_DBG_PC, 32'h00400000 + 32'(c));
         rchk(REG_DBG_SP, ~(32'h00400000 + 32'(c)));
      end
      core.wr(REG_DBG_THREAD_SEL, 32'hFFFFFFFF);
      core.wr(REG_DBG_REG_SEL, 32'hFFFFFFFF);
      rchk(REG_DBG_THREAD_SEL, 32'h000000FF);
      rchk(REG_DBG_REG_SEL, 32'h0000001F);
      chk("fetch operands", 32'h1FFF, {19'h0, ft, fr});
      @(posedge clk) dm <= 1'b0;
      core.wr(REG_DBG_REG_SEL, 32'h0);
      core.wr(REG_DBG_PC, 32'h0);
      rchk(REG_DBG_REG_SEL, 32'h0000001F);
      rchk(REG_DBG_PC, 32'h00400005);
      wrap_up();
   end
endmodule
bind csd_regs csd_regs_properties #(.RAM_BYTES(RAM_BYTES)) u_props (
   .REF_CLK(REF_CLK), .RST(RST), .PS_WRITE(PS_WRITE), .PS_READ(PS_READ),
   .PS_NUM(PS_NUM), .PS_WDATA(PS_WDATA), .PS_RDATA(PS_RDATA),
   .PS_RVALID(PS_RVALID), .OTP_LOAD(OTP_LOAD), .OTP_WORD(OTP_WORD),
   .DEBUG_MODE(DEBUG_MODE), .NO_GLOBAL_DEBUG(NO_GLOBAL_DEBUG),
   .NO_SCAN_DEBUG(NO_SCAN_DEBUG), .BOOT_FROM_OTP(BOOT_FROM_OTP),
   .FETCH_THREAD(FETCH_THREAD), .FETCH_REG(FETCH_REG),
   .CORE_OSC_EN(CORE_OSC_EN));
